// [bench/testbench.sv]
// Self-checking bench for the receive frame configuration registers.
// Assumes the zero wait state APB slave and one-cycle strobes of the design.
`timescale 1ns/1ps
module testbench;
  // Clock, reset and design ports.
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic pready;
  logic [31:0] prdata;
  logic pslverr;
  logic frame_done = 1'b0;
  logic [2:0] frame_chan = 3'h0;
  logic [15:0] frame_byte_count = 16'h0000;
  logic frame_crc_err = 1'b0;
  logic frame_code_err = 1'b0;
  logic frame_align_err = 1'b0;
  logic [7:0] frame_bufs_used = 8'h00;
  logic class_valid;
  logic frame_long;
  logic frame_oversized;
  logic frame_jabber;
  logic sop_req = 1'b0;
  logic [31:0] sop_buf_addr = 32'h00000000;
  logic sop_desc_valid;
  logic [15:0] sop_desc_offset;
  logic [31:0] sop_data_addr;
  logic [7:0] rx_unicast_on;
  logic [7:0] low_prio_filter;
  int fail_count = 0;
  int n_tests = 0;
  int cycles = 0;
  logic [31:0] rd;
  logic err;

  mac_rx_frame_config_regs mac_rx_frame_config_regs_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .frame_done(frame_done),
    .frame_chan(frame_chan), .frame_byte_count(frame_byte_count),
    .frame_crc_err(frame_crc_err), .frame_code_err(frame_code_err),
    .frame_align_err(frame_align_err), .frame_bufs_used(frame_bufs_used),
    .class_valid(class_valid), .frame_long(frame_long),
    .frame_oversized(frame_oversized), .frame_jabber(frame_jabber),
    .sop_req(sop_req), .sop_buf_addr(sop_buf_addr),
    .sop_desc_valid(sop_desc_valid), .sop_desc_offset(sop_desc_offset),
    .sop_data_addr(sop_data_addr), .rx_unicast_on(rx_unicast_on),
    .low_prio_filter(low_prio_filter)
  );

  // A 50 MHz clock.
  always #10 pclk = ~pclk;

  // The whole run needs about 150 cycles, so this ceiling means a hang.
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count = fail_count + 1;
      $display("Error at %0t: run did not finish", $time);
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("Checks made %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Compares one value; four-state equality so unknowns never match.
  task automatic check(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
    n_tests = n_tests + 1;
    if (got !== exp) begin
      fail_count = fail_count + 1;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // One APB transfer; held until pready is seen high at a rising edge.
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the bench timeout ends a wait that never sees pready.
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
    // The register takes the write at this edge, so let it settle.
    #1;
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    logic e;
    apb(1'b0, a, 32'h00000000, rd, e);
    check(rd, exp, "read data");
    check({31'h0, e}, 32'h0, "pslverr on mapped read");
  endtask

  // Sends a frame report; exp is {long, oversized, jabber}.
  task automatic frame(input logic [2:0] ch, input logic [15:0] cnt,
                       input logic [2:0] errs, input logic [7:0] bufs,
                       input logic [2:0] exp);
    @(posedge pclk);
    frame_done <= 1'b1;
    frame_chan <= ch;
    frame_byte_count <= cnt;
    {frame_crc_err, frame_code_err, frame_align_err} <= errs;
    frame_bufs_used <= bufs;
    @(posedge pclk);
    frame_done <= 1'b0;
    #1;
    check({31'h0, class_valid}, 32'h1, "class_valid pulse");
    check({29'h0, frame_long, frame_oversized, frame_jabber},
          {29'h0, exp}, "frame class");
    @(posedge pclk);
    #1;
    check({31'h0, class_valid}, 32'h0, "class_valid one cycle");
  endtask

  task automatic test_reset();
    check({31'h0, pready}, 32'h1, "pready");
    check({24'h0, rx_unicast_on}, 32'h0, "unicast reset");
    rd_chk(rx_cfg_pkg::OFF_UNI_SET, 32'h00000000);
    rd_chk(rx_cfg_pkg::OFF_MAX_LEN, 32'h000005EE);
    rd_chk(rx_cfg_pkg::OFF_BUF_OFFSET, 32'h00000000);
    rd_chk(rx_cfg_pkg::OFF_LOW_THRESH, 32'h00000000);
    check({24'h0, low_prio_filter}, 32'h0, "no filter at zero");
    $display("test_reset done");
  endtask

  task automatic test_unicast();
    wr(rx_cfg_pkg::OFF_UNI_SET, 32'hFFFFFF21);
    wr(rx_cfg_pkg::OFF_UNI_SET, 32'h00000084);
    check({24'h0, rx_unicast_on}, 32'h000000A5, "set ors in");
    rd_chk(rx_cfg_pkg::OFF_UNI_SET, 32'h000000A5);
    wr(rx_cfg_pkg::OFF_UNI_CLEAR, 32'hFFFFFF81);
    check({24'h0, rx_unicast_on}, 32'h00000024, "clear");
    rd_chk(rx_cfg_pkg::OFF_UNI_CLEAR, 32'h00000024);
    wr(rx_cfg_pkg::OFF_UNI_CLEAR, 32'h00000000);
    wr(rx_cfg_pkg::OFF_UNI_SET, 32'h00000000);
    check({24'h0, rx_unicast_on}, 32'h00000024, "zero no effect");
    wr(rx_cfg_pkg::OFF_UNI_SET, 32'h000000FF);
    check({24'h0, rx_unicast_on}, 32'h000000FF, "all on");
    $display("test_unicast done");
  endtask

  task automatic test_max_len();
    frame(3'h1, 16'h05EE, 3'b000, 8'h00, 3'b000);
    frame(3'h1, 16'h05EF, 3'b000, 8'h00, 3'b110);
    wr(rx_cfg_pkg::OFF_MAX_LEN, 32'hFFFF0064);
    rd_chk(rx_cfg_pkg::OFF_MAX_LEN, 32'h00000064);
    frame(3'h0, 16'h0064, 3'b100, 8'h00, 3'b000);
    frame(3'h0, 16'h0065, 3'b000, 8'h00, 3'b110);
    frame(3'h0, 16'h0065, 3'b100, 8'h00, 3'b101);
    frame(3'h0, 16'h0065, 3'b010, 8'h00, 3'b101);
    frame(3'h0, 16'h0065, 3'b001, 8'h00, 3'b101);
    $display("test_max_len done");
  endtask

  // Sends back-to-back descriptor requests on two buffers.
  task automatic test_sop();
    wr(rx_cfg_pkg::OFF_BUF_OFFSET, 32'hABCD000F);
    rd_chk(rx_cfg_pkg::OFF_BUF_OFFSET, 32'h0000000F);
    for (int i = 0; i < 2; i++) begin
      @(posedge pclk);
      sop_req <= 1'b1;
      sop_buf_addr <= 32'hFFFFFFF8 - 32'(i * 32'h100);
      @(posedge pclk);
      #1;
      check({31'h0, sop_desc_valid}, 32'h1, "sop valid");
      check({16'h0, sop_desc_offset}, 32'h0000000F, "sop offset");
      check(sop_data_addr, 32'h00000007 - 32'(i * 32'h100),
            "data addr");
    end
    @(posedge pclk);
    sop_req <= 1'b0;
    wr(rx_cfg_pkg::OFF_BUF_OFFSET, 32'h00000000);
    @(posedge pclk);
    sop_req <= 1'b1;
    sop_buf_addr <= 32'h12345678;
    @(posedge pclk);
    sop_req <= 1'b0;
    #1;
    check(sop_data_addr, 32'h12345678, "zero offset");
    @(posedge pclk);
    #1;
    check({31'h0, sop_desc_valid}, 32'h0, "sop valid one cycle");
    $display("test_sop done");
  endtask

  task automatic test_free_filter();
    wr(rx_cfg_pkg::OFF_LOW_THRESH, 32'hFFFFFF04);
    rd_chk(rx_cfg_pkg::OFF_LOW_THRESH, 32'h00000004);
    for (int c = 0; c < 8; c++) begin
      wr(rx_cfg_pkg::OFF_FREE_BASE + 12'(4 * c), 32'h00000006);
    end
    repeat (2) @(posedge pclk);
    #1;
    check({24'h0, low_prio_filter}, 32'h0, "count above level");
    frame(3'h2, 16'h0040, 3'b000, 8'h03, 3'b000);
    repeat (2) @(posedge pclk);
    #1;
    check({24'h0, low_prio_filter}, 32'h00000004, "ch2 filtered");
    rd_chk(rx_cfg_pkg::OFF_FREE_BASE + 12'h008, 32'h00000003);
    rd_chk(rx_cfg_pkg::OFF_FREE_BASE + 12'h01C, 32'h00000006);
    wr(rx_cfg_pkg::OFF_LOW_THRESH, 32'h00000000);
    repeat (2) @(posedge pclk);
    #1;
    check({24'h0, low_prio_filter}, 32'h0, "zero level");
    $display("test_free_filter done");
  endtask

  task automatic test_unmapped();
    wr(12'h014, 32'hFFFFFFFF);
    apb(1'b0, 12'h014, 32'h00000000, rd, err);
    check(rd, 32'h00000000, "unmapped read data");
    check({31'h0, err}, 32'h1, "unmapped pslverr");
    apb(1'b1, 12'h040, 32'h00000001, rd, err);
    check({31'h0, err}, 32'h1, "unmapped write pslverr");
    rd_chk(rx_cfg_pkg::OFF_UNI_SET, 32'h000000FF);
    $display("test_unmapped done");
  endtask

  // Main sequence: reset for six cycles, then each scenario in turn.
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    test_reset();
    test_unicast();
    test_max_len();
    test_sop();
    test_free_filter();
    test_unmapped();
    print_verdict();
  end
endmodule

// [logic/mac_rx_frame_config_regs.sv]
// Receive frame configuration registers of the MAC, with APB access.
// Assumes one APB master and synchronous frame and descriptor strobes.
//
// Our own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module mac_rx_frame_config_regs (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // Finished frame report from the receive path.
  input wire logic frame_done,
  input wire logic [2:0] frame_chan,
  input wire logic [15:0] frame_byte_count,
  input wire logic frame_crc_err,
  input wire logic frame_code_err,
  input wire logic frame_align_err,
  input wire logic [7:0] frame_bufs_used,
  // Frame classification.
  output logic class_valid,
  output logic frame_long,
  output logic frame_oversized,
  output logic frame_jabber,
  // Start-of-packet descriptor fill.
  input wire logic sop_req,
  input wire logic [31:0] sop_buf_addr,
  output logic sop_desc_valid,
  output logic [15:0] sop_desc_offset,
  output logic [31:0] sop_data_addr,
  // Configuration and state seen by the receive path.
  output logic [7:0] rx_unicast_on,
  output logic [7:0] low_prio_filter
);

  logic setup_phase;
  logic wr_go;
  logic [7:0] uni_en;
  logic [15:0] max_frame_bytes;
  logic [15:0] sop_data_offset;
  logic [7:0] low_prio_filter_level;
  logic [7:0] host_inc;
  logic [7:0][15:0] channel_free_buffer_count;
  logic free_hit;
  logic [2:0] free_chan;
  logic [31:0] next_prdata;
  logic next_pslverr;

  // Zero wait states: every access phase completes at once.
  assign pready = 1'b1;
  assign setup_phase = psel & ~penable;
  assign wr_go = psel & penable & pwrite;
  assign rx_unicast_on = uni_en;

  // Free count words are decoded as a block of eight aligned words.
  assign free_hit = (paddr[11:5] == rx_cfg_pkg::OFF_FREE_BASE[11:5]) &&
                    (paddr[1:0] == 2'h0);
  assign free_chan = paddr[4:2];

  // Set and clear act on one vector; set wins when both reach a bit.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      uni_en <= rx_cfg_pkg::UNI_RESET;
    end else if (wr_go && paddr == rx_cfg_pkg::OFF_UNI_SET) begin
      uni_en <= uni_en | pwdata[7:0];
    end else if (wr_go && paddr == rx_cfg_pkg::OFF_UNI_CLEAR) begin
      uni_en <= uni_en & ~pwdata[7:0];
    end
  end

  // Maximum frame length, the upper half of the word is dropped.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      max_frame_bytes <= rx_cfg_pkg::MAX_LEN_RESET;
    end else if (wr_go && paddr == rx_cfg_pkg::OFF_MAX_LEN) begin
      max_frame_bytes <= pwdata[15:0];
    end
  end

  // One buffer offset for every channel; no per-channel copy is kept.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sop_data_offset <= rx_cfg_pkg::OFFSET_RESET;
    end else if (wr_go && paddr == rx_cfg_pkg::OFF_BUF_OFFSET) begin
      sop_data_offset <= pwdata[15:0];
    end
  end

  // Low priority filter level; zero leaves filtering off.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_prio_filter_level <= rx_cfg_pkg::THRESH_RESET;
    end else if (wr_go && paddr == rx_cfg_pkg::OFF_LOW_THRESH) begin
      low_prio_filter_level <= pwdata[7:0];
    end
  end

  // A write to a free count word adds to that channel's counter.
  always_comb begin
    host_inc = 8'h00;
    if (wr_go && free_hit) begin
      host_inc[free_chan] = 1'b1;
    end
  end

  // Read data is captured in the setup phase so prdata is a flop;
  // a counter that moves in that one cycle reads one cycle stale.
  always_comb begin
    next_prdata = 32'h0000_0000;
    next_pslverr = 1'b0;
    if (free_hit) begin
      next_prdata = {16'h0000, channel_free_buffer_count[free_chan]};
    end else begin
      case (paddr)
        rx_cfg_pkg::OFF_UNI_SET: begin
          next_prdata = {24'h00_0000, uni_en};
        end
        rx_cfg_pkg::OFF_UNI_CLEAR: begin
          next_prdata = {24'h00_0000, uni_en};
        end
        rx_cfg_pkg::OFF_MAX_LEN: begin
          next_prdata = {16'h0000, max_frame_bytes};
        end
        rx_cfg_pkg::OFF_BUF_OFFSET: begin
          next_prdata = {16'h0000, sop_data_offset};
        end
        rx_cfg_pkg::OFF_LOW_THRESH: begin
          next_prdata = {24'h00_0000, low_prio_filter_level};
        end
        default: begin
          next_pslverr = 1'b1;
        end
      endcase
    end
  end

  // Read data and error answer.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (setup_phase) begin
      prdata <= pwrite ? 32'h0000_0000 : next_prdata;
      pslverr <= next_pslverr;
    end
  end

  // Descriptor fill answers one cycle after each request.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sop_desc_valid <= 1'b0;
      sop_desc_offset <= 16'h0000;
      sop_data_addr <= 32'h0000_0000;
    end else begin
      sop_desc_valid <= sop_req;
      if (sop_req) begin
        sop_desc_offset <= sop_data_offset;
        sop_data_addr <= sop_buf_addr + {16'h0000, sop_data_offset};
      end
    end
  end

  // Long, oversized and jabber sorting.
  rx_frame_classifier u_classifier (
    .pclk(pclk),
    .presetn(presetn),
    .max_frame_bytes(max_frame_bytes),
    .frame_done(frame_done),
    .frame_byte_count(frame_byte_count),
    .frame_crc_err(frame_crc_err),
    .frame_code_err(frame_code_err),
    .frame_align_err(frame_align_err),
    .class_valid(class_valid),
    .frame_long(frame_long),
    .frame_oversized(frame_oversized),
    .frame_jabber(frame_jabber)
  );

  // Free buffer bookkeeping and filter decisions.
  rx_free_buffer_tracker u_tracker (
    .pclk(pclk),
    .presetn(presetn),
    .host_inc(host_inc),
    .host_inc_value(pwdata[15:0]),
    .frame_done(frame_done),
    .frame_chan(frame_chan),
    .frame_bufs_used(frame_bufs_used),
    .low_prio_filter_level(low_prio_filter_level),
    .channel_free_buffer_count(channel_free_buffer_count),
    .low_prio_filter(low_prio_filter)
  );

  // Per-channel comparison that the filter flags must follow a cycle later.
  logic [7:0] below_level;
  genvar fc;
  generate
    for (fc = 0; fc < rx_cfg_pkg::NUM_CHAN; fc++) begin : g_below
      assign below_level[fc] = channel_free_buffer_count[fc] <
                               {8'h00, low_prio_filter_level};
    end
  endgenerate

  // Checks on the behaviour above, all in the pclk domain.
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_wr_set;
    wr_go && paddr == rx_cfg_pkg::OFF_UNI_SET;
  endsequence

  sequence s_wr_clear;
    wr_go && paddr == rx_cfg_pkg::OFF_UNI_CLEAR;
  endsequence

  sequence s_rd_setup(logic [11:0] addr);
    setup_phase && !pwrite && paddr == addr;
  endsequence

  property p_set_ones;
    s_wr_set |=> uni_en == ($past(uni_en) | $past(pwdata[7:0]));
  endproperty
  a_set_ones: assert property (p_set_ones)
    else $error("Set write did not OR into the unicast enables.");

  property p_clear_ones;
    s_wr_clear |=> uni_en == ($past(uni_en) & ~$past(pwdata[7:0]));
  endproperty
  a_clear_ones: assert property (p_clear_ones)
    else $error("Clear write did not remove the unicast enables.");

  property p_enables_still;
    !(wr_go && (paddr == rx_cfg_pkg::OFF_UNI_SET ||
      paddr == rx_cfg_pkg::OFF_UNI_CLEAR)) |=> $stable(uni_en);
  endproperty
  a_enables_still: assert property (p_enables_still)
    else $error("Unicast enables changed without a set or clear write.");

  property p_read_set;
    s_rd_setup(rx_cfg_pkg::OFF_UNI_SET) |=>
      prdata == {24'h00_0000, $past(uni_en)} && !pslverr;
  endproperty
  a_read_set: assert property (p_read_set)
    else $error("Set register read did not return the enables.");

  property p_read_max_len;
    s_rd_setup(rx_cfg_pkg::OFF_MAX_LEN) |=>
      prdata[31:16] == 16'h0000 && prdata[15:0] == $past(max_frame_bytes);
  endproperty
  a_read_max_len: assert property (p_read_max_len)
    else $error("Maximum length read returned a wrong value.");

  property p_threshold_write;
    wr_go && paddr == rx_cfg_pkg::OFF_LOW_THRESH |=>
      low_prio_filter_level == $past(pwdata[7:0]);
  endproperty
  a_threshold_write: assert property (p_threshold_write)
    else $error("Filter threshold write was not stored.");

  property p_long;
    frame_done |=> class_valid &&
      frame_long == ($past(frame_byte_count) > $past(max_frame_bytes));
  endproperty
  a_long: assert property (p_long)
    else $error("Long frame flag does not match the length limit.");

  property p_oversized;
    class_valid && frame_long && !$past(frame_crc_err) &&
      !$past(frame_code_err) && !$past(frame_align_err) |->
      frame_oversized && !frame_jabber;
  endproperty
  a_oversized: assert property (p_oversized)
    else $error("Error free long frame was not marked oversized.");

  property p_jabber;
    class_valid && frame_long && ($past(frame_crc_err) ||
      $past(frame_code_err) || $past(frame_align_err)) |->
      frame_jabber && !frame_oversized;
  endproperty
  a_jabber: assert property (p_jabber)
    else $error("Long frame with an error was not marked jabber.");

  property p_sop_fill;
    sop_req |=> sop_desc_valid && sop_desc_offset == $past(sop_data_offset)
      && sop_data_addr == $past(sop_buf_addr) +
      {16'h0000, $past(sop_data_offset)};
  endproperty
  a_sop_fill: assert property (p_sop_fill)
    else $error("Descriptor offset or data address is wrong.");

  property p_filter;
    1'b1 |=> low_prio_filter == $past(below_level);
  endproperty
  a_filter: assert property (p_filter)
    else $error("Low priority filter flag disagrees with the count.");

  property p_decrement;
    frame_done && !host_inc[frame_chan] |=>
      channel_free_buffer_count[$past(frame_chan)] ==
      $past(channel_free_buffer_count[frame_chan]) -
      {8'h00, $past(frame_bufs_used)};
  endproperty
  a_decrement: assert property (p_decrement)
    else $error("Free count did not drop by the buffers used.");

endmodule

// [logic/rx_cfg_pkg.sv]
// Shared constants of the receive frame configuration block.
// Assumes a 32-bit APB register port with word aligned offsets.
package rx_cfg_pkg;

  // Structure of the block.
  localparam int NUM_CHAN = 8;
  localparam int CHAN_W = 3;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;

  // Register byte offsets.
  localparam logic [11:0] OFF_UNI_SET = 12'h000;
  localparam logic [11:0] OFF_UNI_CLEAR = 12'h004;
  localparam logic [11:0] OFF_MAX_LEN = 12'h008;
  localparam logic [11:0] OFF_BUF_OFFSET = 12'h00C;
  localparam logic [11:0] OFF_LOW_THRESH = 12'h010;
  // Eight free buffer count words start here, one word per channel.
  localparam logic [11:0] OFF_FREE_BASE = 12'h020;

  // Field widths, all fields start at bit 0.
  localparam int UNI_W = 8;
  localparam int LEN_W = 16;
  localparam int OFFSET_W = 16;
  localparam int THRESH_W = 8;
  localparam int FREE_W = 16;
  localparam int BUFS_W = 8;

  // Reset values.
  localparam logic [7:0] UNI_RESET = 8'h00;
  localparam logic [15:0] MAX_LEN_RESET = 16'h05EE;
  localparam logic [15:0] OFFSET_RESET = 16'h0000;
  localparam logic [7:0] THRESH_RESET = 8'h00;
  localparam logic [15:0] FREE_RESET = 16'h0000;

endpackage

// [logic/rx_frame_classifier.sv]
// Sorts each finished receive frame into long, oversized and jabber.
// Assumes frame_done is a one-cycle pulse with its count and error flags.
`timescale 1ns/1ps
module rx_frame_classifier (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Programmed limit.
  input wire logic [15:0] max_frame_bytes,
  // Finished frame report.
  input wire logic frame_done,
  input wire logic [15:0] frame_byte_count,
  input wire logic frame_crc_err,
  input wire logic frame_code_err,
  input wire logic frame_align_err,
  // Classification, one cycle after frame_done.
  output logic class_valid,
  output logic frame_long,
  output logic frame_oversized,
  output logic frame_jabber
);

  logic is_long;
  logic has_err;

  // Equal to the limit is still a legal frame.
  assign is_long = frame_byte_count > max_frame_bytes;
  assign has_err = frame_crc_err | frame_code_err | frame_align_err;

  // Results are held until the next frame replaces them.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      class_valid <= 1'b0;
      frame_long <= 1'b0;
      frame_oversized <= 1'b0;
      frame_jabber <= 1'b0;
    end else begin
      class_valid <= frame_done;
      if (frame_done) begin
        frame_long <= is_long;
        frame_oversized <= is_long & ~has_err;
        frame_jabber <= is_long & has_err;
      end
    end
  end

endmodule

// [logic/rx_free_buffer_tracker.sv]
// Per-channel free buffer counters and the low priority filter flags.
// Assumes the host increments and the receive path decrements.
`timescale 1ns/1ps
module rx_free_buffer_tracker (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Host write-to-increment, one strobe per channel.
  input wire logic [7:0] host_inc,
  input wire logic [15:0] host_inc_value,
  // Buffers consumed by a finished frame.
  input wire logic frame_done,
  input wire logic [2:0] frame_chan,
  input wire logic [7:0] frame_bufs_used,
  // Filter level.
  input wire logic [7:0] low_prio_filter_level,
  // State.
  output logic [7:0][15:0] channel_free_buffer_count,
  output logic [7:0] low_prio_filter
);

  genvar ch;
  generate
    for (ch = 0; ch < rx_cfg_pkg::NUM_CHAN; ch++) begin : g_chan
      logic take;
      logic [15:0] next_count;

      assign take = frame_done && (frame_chan == 3'(ch));

      // Increment and decrement in one cycle both apply; counts wrap.
      always_comb begin
        next_count = channel_free_buffer_count[ch];
        if (host_inc[ch]) begin
          next_count = next_count + host_inc_value;
        end
        if (take) begin
          next_count = next_count - {8'h00, frame_bufs_used};
        end
      end

      // Counter register.
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          channel_free_buffer_count[ch] <= rx_cfg_pkg::FREE_RESET;
        end else begin
          channel_free_buffer_count[ch] <= next_count;
        end
      end

      // A level of zero never filters, since no count is below zero.
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          low_prio_filter[ch] <= 1'b0;
        end else begin
          low_prio_filter[ch] <= channel_free_buffer_count[ch] <
                                 {8'h00, low_prio_filter_level};
        end
      end
    end
  endgenerate

endmodule
